//--- common/fmd_pkg.sv
/*
 * Constants, encodings and field layouts for the fused multiply-add operand
 * decoder and its integer multiply-add companion.
 * Assumes one core clock and a pipeline that issues one decoded instruction
 * per cycle at most, with exception conditions already evaluated.
 */
package fmd_pkg;

    // ----------------------------------------
    // Register map of the plain register port
    // ----------------------------------------
    localparam logic [3:0] FMD_ADDR_CONFIG = 4'h0;
    localparam logic [3:0] FMD_ADDR_STATUS = 4'h4;
    localparam logic [3:0] FMD_ADDR_OPTION = 4'h8;

    // CONFIG fields.
    localparam int FMD_CFG_TEM_LSB = 0;
    localparam int FMD_CFG_NS_BIT = 8;
    localparam int FMD_CFG_FPEN_BIT = 9;
    localparam logic [4:0] FMD_CFG_TEM_RESET = 5'h00;
    localparam logic FMD_CFG_NS_RESET = 1'b0;
    localparam logic FMD_CFG_FPEN_RESET = 1'b1;

    // STATUS fields.
    localparam int FMD_STS_CEXC_LSB = 0;
    localparam int FMD_STS_AEXC_LSB = 5;
    localparam int FMD_STS_FTT_LSB = 14;

    // ----------------------------------------
    // Exception flag positions
    // ----------------------------------------
    localparam int FMD_EXC_NV = 4;
    localparam int FMD_EXC_OF = 3;
    localparam int FMD_EXC_UF = 2;
    localparam int FMD_EXC_DZ = 1;
    localparam int FMD_EXC_NX = 0;
    localparam logic [4:0] FMD_MUL_TRAP_MASK = 5'h11;

    // Trap-type codes for no trap and for an incomplete operation.
    localparam logic [2:0] FMD_FTT_NONE = 3'h0;
    localparam logic [2:0] FMD_FTT_INCOMPLETE = 3'h2;

    // ----------------------------------------
    // Opcode fields
    // ----------------------------------------
    typedef enum logic [1:0] {
        FMD_VAR_MADD = 2'b00,
        FMD_VAR_MSUB = 2'b01,
        FMD_VAR_NMSUB = 2'b10,
        FMD_VAR_NMADD = 2'b11
    } fmd_var_type;

    localparam logic [1:0] FMD_SIZE_INT = 2'b00;
    localparam logic [1:0] FMD_SIZE_SINGLE = 2'b01;
    localparam logic [1:0] FMD_SIZE_DOUBLE = 2'b10;
    localparam logic [1:0] FMD_SIZE_QUAD = 2'b11;

    localparam int FMD_REG_W = 9;
    localparam int FMD_DATA_W = 64;

endpackage : fmd_pkg

//--- verilog/fmd_operand_decode.sv
/*
 * Operand decoder and integer multiply-add datapath for fused multiply
 * instructions, basic and extended halves.
 * Assumes the pipeline drives all issue inputs from core_clk logic, holds
 * them for the single cycle of issueValid, and supplies the exception
 * conditions that the floating-point arithmetic found for this instruction.
 */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns
module fmd_operand_decode (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEnable,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // Instruction issue
    input wire logic issueValid,
    input wire fmd_pkg::fmd_var_type varField,
    input wire logic [1:0] sizeField,
    input wire logic [4:0] first_multiplicand_field,
    input wire logic [4:0] second_multiplicand_field,
    input wire logic [4:0] addend_field,
    input wire logic [4:0] destField,
    input wire logic simd_prefix_flag,
    input wire logic [2:0] prefix_src1_extension,
    input wire logic [2:0] prefix_src2_extension,
    input wire logic [2:0] prefix_addend_extension,
    input wire logic [2:0] prefix_dest_extension,
    // Operand values for the integer form
    input wire logic [63:0] opMulABasic,
    input wire logic [63:0] opMulBBasic,
    input wire logic [63:0] opAddBasic,
    input wire logic [63:0] opMulAExt,
    input wire logic [63:0] opMulBExt,
    input wire logic [63:0] opAddExt,
    // Exception conditions from the arithmetic
    input wire logic [4:0] mulExc,
    input wire logic [4:0] addExc,
    input wire logic denormSource,
    input wire logic incomplete_fp_operation,
    // Decoded results
    output logic done,
    output logic intOp,
    output logic simdOp,
    output logic [8:0] src1Basic,
    output logic [8:0] src1Ext,
    output logic [8:0] src2Basic,
    output logic [8:0] src2Ext,
    output logic [8:0] addendBasic,
    output logic [8:0] addendExt,
    output logic [8:0] destBasic,
    output logic [8:0] destExt,
    output logic negProdBasic,
    output logic negProdExt,
    output logic subAddend,
    output logic roundOnce,
    output logic skipAdd,
    output logic [63:0] resultBasic,
    output logic [63:0] resultExt,
    // Traps
    output logic illegalTrap,
    output logic fpu_off_trap,
    output logic ieee_fp_trap,
    output logic other_fp_trap
);
    import fmd_pkg::*;

    typedef struct packed {
        logic done;
        logic intOp;
        logic simdOp;
        logic [8:0] src1Basic;
        logic [8:0] src1Ext;
        logic [8:0] src2Basic;
        logic [8:0] src2Ext;
        logic [8:0] addendBasic;
        logic [8:0] addendExt;
        logic [8:0] destBasic;
        logic [8:0] destExt;
        logic negProdBasic;
        logic negProdExt;
        logic subAddend;
        logic roundOnce;
        logic skipAdd;
        logic [63:0] resultBasic;
        logic [63:0] resultExt;
        logic illegalTrap;
        logic fpuOff;
        logic ieeeTrap;
        logic otherTrap;
        logic [4:0] cexc;
        logic [4:0] aexc;
        logic [2:0] ftt;
        logic [4:0] trapEnable;
        logic nonstandard_mode_bit;
        logic fpEnable;
        logic [31:0] rdData;
    } fmd_state_type;

    fmd_state_type st;
    fmd_state_type next_st;

    // ----------------------------------------
    // Register number decode
    // ----------------------------------------
    // A double register field carries its bit 5 in the field's bit 0.
    function automatic logic [5:0] dblField(input logic [4:0] f);
        dblField = {f[0], f[4:1], 1'b0};
    endfunction : dblField

    logic isFma;
    logic isIntMa;
    logic isIllegal;
    logic simdFma;
    logic [8:0] s1b, s1i, s2b, s2i, s3b, s3e, sdb, sde;
    logic [127:0] fullBasic;
    logic [127:0] fullExt;

    assign isFma = (sizeField == FMD_SIZE_SINGLE) || (sizeField == FMD_SIZE_DOUBLE);
    assign isIntMa = (sizeField == FMD_SIZE_INT) && !varField[1];
    assign isIllegal = (sizeField == FMD_SIZE_QUAD) && (varField != FMD_VAR_NMADD);
    assign simdFma = simd_prefix_flag && isFma;

    // Multiplicands keep all three extension bits; bit 8 flips for extended.
    assign s1b = {prefix_src1_extension, dblField(first_multiplicand_field)};
    assign s1i = {~prefix_src1_extension[2], prefix_src1_extension[1:0],
                  dblField(first_multiplicand_field)};
    assign s2b = {prefix_src2_extension, dblField(second_multiplicand_field)};
    assign s2i = {~prefix_src2_extension[2], prefix_src2_extension[1:0],
                  dblField(second_multiplicand_field)};
    // Addend and destination force bit 8, so extension bit 2 is free as an option.
    assign s3b = {1'b0, prefix_addend_extension[1:0], dblField(addend_field)};
    assign s3e = {1'b1, prefix_addend_extension[1:0], dblField(addend_field)};
    assign sdb = {1'b0, prefix_dest_extension[1:0], dblField(destField)};
    assign sde = {1'b1, prefix_dest_extension[1:0], dblField(destField)};

    // Two separate multipliers so neither half waits on the other.
    assign fullBasic = 128'(opMulABasic) * 128'(opMulBBasic) + 128'(opAddBasic);
    assign fullExt = 128'(opMulAExt) * 128'(opMulBExt) + 128'(opAddExt);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic [4:0] mulTrapBits;
    logic [4:0] addTrapBits;
    logic mulTraps;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.rdData = 32'h0;
        next_st.illegalTrap = 1'b0;
        next_st.fpuOff = 1'b0;
        next_st.ieeeTrap = 1'b0;
        next_st.otherTrap = 1'b0;
        mulTrapBits = mulExc & st.trapEnable & FMD_MUL_TRAP_MASK;
        addTrapBits = addExc & st.trapEnable;
        mulTraps = (mulTrapBits != 5'h00) || (denormSource && st.nonstandard_mode_bit);

        if (regWrite && regAddr == FMD_ADDR_CONFIG) begin
            next_st.trapEnable = regWrData[FMD_CFG_TEM_LSB +: 5];
            next_st.nonstandard_mode_bit = regWrData[FMD_CFG_NS_BIT];
            next_st.fpEnable = regWrData[FMD_CFG_FPEN_BIT];
        end
        if (regRead) begin
            case (regAddr)
                FMD_ADDR_CONFIG: begin
                    next_st.rdData = {22'h0, st.fpEnable, st.nonstandard_mode_bit,
                                      3'h0, st.trapEnable};
                end
                FMD_ADDR_STATUS: begin
                    next_st.rdData = {15'h0, st.ftt, 4'h0, st.aexc, st.cexc};
                end
                FMD_ADDR_OPTION: begin
                    next_st.rdData = {29'h0, st.simdOp, st.negProdExt, st.skipAdd};
                end
                default: begin
                    next_st.rdData = 32'h0;
                end
            endcase
        end

        if (issueValid && (isFma || isIntMa || isIllegal)) begin
            next_st.done = 1'b1;
            next_st.intOp = isIntMa && !isIllegal;
            next_st.simdOp = simd_prefix_flag;
            next_st.skipAdd = 1'b0;
            next_st.roundOnce = isFma;
            next_st.negProdBasic = varField[1];
            next_st.subAddend = varField[0];
            next_st.negProdExt = varField[1] ^ (simdFma & prefix_dest_extension[2]);
            next_st.src1Basic = s1b;
            next_st.src2Basic = s2b;
            next_st.src2Ext = s2i;
            if (simdFma) begin
                next_st.src1Ext = prefix_addend_extension[2] ? s1b : s1i;
                next_st.addendBasic = s3b;
                next_st.addendExt = s3e;
                next_st.destBasic = sdb;
                next_st.destExt = sde;
            end else begin
                // Outside a SIMD fused form (no SIMD flag, or integer form) all nine bits select the basic addend and destination.
                next_st.src1Ext = s1i;
                next_st.addendBasic = {prefix_addend_extension, dblField(addend_field)};
                next_st.addendExt = s3e;
                next_st.destBasic = {prefix_dest_extension, dblField(destField)};
                next_st.destExt = sde;
            end
            next_st.resultBasic = 64'h0;
            next_st.resultExt = 64'h0;
            if (isIllegal) begin
                next_st.illegalTrap = 1'b1;
            end else if (!st.fpEnable) begin
                next_st.fpuOff = 1'b1;
            end else if (isIntMa) begin
                // Integer form leaves cexc, aexc and ftt untouched.
                next_st.resultBasic = varField[0] ? fullBasic[127:64] : fullBasic[63:0];
                next_st.resultExt = varField[0] ? fullExt[127:64] : fullExt[63:0];
            end else if (incomplete_fp_operation) begin
                next_st.otherTrap = 1'b1;
                next_st.ftt = FMD_FTT_INCOMPLETE;
            end else if (mulTraps) begin
                next_st.ieeeTrap = 1'b1;
                next_st.skipAdd = 1'b1;
                next_st.cexc = mulExc;
                next_st.ftt = FMD_FTT_NONE;
            end else if (addTrapBits != 5'h00) begin
                next_st.ieeeTrap = 1'b1;
                next_st.cexc = addTrapBits;
                next_st.ftt = FMD_FTT_NONE;
            end else begin
                next_st.cexc = mulExc | addExc;
                next_st.aexc = st.aexc | mulExc | addExc;
                next_st.ftt = FMD_FTT_NONE;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.trapEnable <= FMD_CFG_TEM_RESET;
            st.nonstandard_mode_bit <= FMD_CFG_NS_RESET;
            st.fpEnable <= FMD_CFG_FPEN_RESET;
        end else if (clkEnable) begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign done = st.done;
    assign intOp = st.intOp;
    assign simdOp = st.simdOp;
    assign src1Basic = st.src1Basic;
    assign src1Ext = st.src1Ext;
    assign src2Basic = st.src2Basic;
    assign src2Ext = st.src2Ext;
    assign addendBasic = st.addendBasic;
    assign addendExt = st.addendExt;
    assign destBasic = st.destBasic;
    assign destExt = st.destExt;
    assign negProdBasic = st.negProdBasic;
    assign negProdExt = st.negProdExt;
    assign subAddend = st.subAddend;
    assign roundOnce = st.roundOnce;
    assign skipAdd = st.skipAdd;
    assign resultBasic = st.resultBasic;
    assign resultExt = st.resultExt;
    assign illegalTrap = st.illegalTrap;
    assign fpu_off_trap = st.fpuOff;
    assign ieee_fp_trap = st.ieeeTrap;
    assign other_fp_trap = st.otherTrap;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seqSimdFmaIssue;
        clkEnable && issueValid && simd_prefix_flag && isFma;
    endsequence

    sequence seqIntIssue;
        clkEnable && issueValid && isIntMa && st.fpEnable;
    endsequence

    AST_ILLEGAL_NO_FPOFF: assert property (
        clkEnable && issueValid && isIllegal |=> illegalTrap && !fpu_off_trap)
        else $error("Illegal encoding not trapped alone.");
    AST_SIMD_RANGE: assert property (
        seqSimdFmaIssue |=> !destBasic[8] && destExt[8] && !addendBasic[8] && addendExt[8])
        else $error("SIMD addend or destination out of range.");
    AST_SRC2_COMPLEMENT: assert property (
        seqSimdFmaIssue |=> src2Ext == (src2Basic ^ 9'h100))
        else $error("Extended second multiplicand not offset by 256.");
    AST_REUSE_SRC1: assert property (
        seqSimdFmaIssue ##0 prefix_addend_extension[2] |=> src1Ext == src1Basic)
        else $error("First multiplicand not reused.");
    AST_NEG_EXT: assert property (
        seqSimdFmaIssue |=> negProdExt == (negProdBasic ^ $past(prefix_dest_extension[2])))
        else $error("Extended product sign wrong.");
    AST_INT_NO_FSR: assert property (
        seqIntIssue ##0 !isIllegal |=> $stable(st.cexc) && $stable(st.aexc) && $stable(st.ftt))
        else $error("Integer multiply-add changed FP state.");
    AST_INT_LOW: assert property (
        seqIntIssue ##0 !varField[0] ##0 !isIllegal |=> resultBasic == $past(fullBasic[63:0]))
        else $error("Low half result wrong.");
    AST_MUL_TRAP_SKIP: assert property (
        clkEnable && issueValid && isFma && st.fpEnable && !incomplete_fp_operation && mulTraps
        |=> ieee_fp_trap && skipAdd && $stable(st.aexc))
        else $error("Multiply trap did not skip add.");
    AST_READ_ONE_CYCLE: assert property (
        clkEnable && !regRead |=> regRdData == 32'h0)
        else $error("Read data stood without a read.");

endmodule : fmd_operand_decode

//--- tb/fmd_pipe_model.sv
/*
 * Pipeline model that offers one decoded instruction per bench request.
 * Assumes the bench raises req for one cycle with the packed fields.
 */
`timescale 1ns/1ns
module fmd_pipe_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bench side
    input wire logic req,
    input wire logic [36:0] instr,
    // Issue side
    output logic issueValid,
    output logic [36:0] fields
);
    // ----------------------------------------
    // Issue
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            issueValid <= 1'b0;
            fields <= '0;
        end else if (req) begin
            issueValid <= 1'b1;
            fields <= instr;
            // The option bits belong to the fused family only.
            if (instr[34:33] == 2'b00 || instr[34:33] == 2'b11) begin
                fields[5] <= 1'b0;
                fields[2] <= 1'b0;
            end
        end else begin
            issueValid <= 1'b0;
            // Idle fields flip every cycle so stale values never look valid.
            fields <= ~fields;
        end
    end
endmodule : fmd_pipe_model

//--- tb/tb.sv
/*
 * Self-checking bench for the fused multiply-add operand decoder.
 * Assumes one core clock and the pipeline model as the issuing party.
 */
`timescale 1ns/1ns
module tb;
    import fmd_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk, rst_n, clkEnable, regWrite, regRead, req, issueValid;
    logic [3:0] regAddr;
    logic [31:0] regWrData, regRdData, d;
    logic [36:0] instr, pf;
    logic [63:0] op [6];
    logic [4:0] mulExc, addExc, tem, cexc, aexc;
    logic denormSource, incomplete_fp_operation, ns, fpEn;
    logic done, intOp, simdOp, negProdBasic, negProdExt, subAddend, roundOnce, skipAdd;
    logic [8:0] src1Basic, src1Ext, src2Basic, src2Ext, addendBasic, addendExt;
    logic [8:0] destBasic, destExt;
    logic [63:0] resultBasic, resultExt, r;
    logic illegalTrap, fpu_off_trap, ieee_fp_trap, other_fp_trap;
    int miscompares, checks_done, cyc;

    fmd_pipe_model i_fmd_pipe_model (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .instr(instr), .issueValid(issueValid), .fields(pf));
    fmd_operand_decode i_fmd_operand_decode (.core_clk(core_clk), .rst_n(rst_n),
        .clkEnable(clkEnable), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .issueValid(issueValid), .varField(fmd_var_type'(pf[36:35])),
        .sizeField(pf[34:33]), .first_multiplicand_field(pf[32:28]),
        .second_multiplicand_field(pf[27:23]), .addend_field(pf[22:18]),
        .destField(pf[17:13]), .simd_prefix_flag(pf[12]), .prefix_src1_extension(pf[11:9]),
        .prefix_src2_extension(pf[8:6]), .prefix_addend_extension(pf[5:3]),
        .prefix_dest_extension(pf[2:0]), .opMulABasic(op[0]), .opMulBBasic(op[1]),
        .opAddBasic(op[2]), .opMulAExt(op[3]), .opMulBExt(op[4]), .opAddExt(op[5]),
        .mulExc(mulExc), .addExc(addExc), .denormSource(denormSource),
        .incomplete_fp_operation(incomplete_fp_operation), .done(done), .intOp(intOp),
        .simdOp(simdOp), .src1Basic(src1Basic), .src1Ext(src1Ext), .src2Basic(src2Basic),
        .src2Ext(src2Ext), .addendBasic(addendBasic), .addendExt(addendExt),
        .destBasic(destBasic), .destExt(destExt), .negProdBasic(negProdBasic),
        .negProdExt(negProdExt), .subAddend(subAddend), .roundOnce(roundOnce),
        .skipAdd(skipAdd), .resultBasic(resultBasic), .resultExt(resultExt),
        .illegalTrap(illegalTrap), .fpu_off_trap(fpu_off_trap),
        .ieee_fp_trap(ieee_fp_trap), .other_fp_trap(other_fp_trap));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    function automatic logic [8:0] rn(input logic [2:0] e, input logic [4:0] f);
        return {e, f[0], f[4:1], 1'b0};
    endfunction : rn

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        q = regRdData;
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic wrap_up();
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic issue_check(input logic [36:0] ins, input logic inc);
        logic [1:0] v, sz;
        logic [4:0] f1, f2, f3, fd;
        logic [2:0] e1, e2, e3, ed;
        logic sm, ign, ill, io, mt, at;
        logic [127:0] fb, fe;
        logic [31:0] q;
        bit got;
        {v, sz, f1, f2, f3, fd, sm, e1, e2, e3, ed} = ins;
        if (sz == 2'b00 || sz == 2'b11) begin
            e3[2] = 1'b0;
            ed[2] = 1'b0;
        end
        ign = (sz == 2'b00 && v[1]) || (sz == 2'b11 && v == 2'b11);
        ill = sz == 2'b11 && v != 2'b11;
        io = sz == 2'b00;
        @(posedge core_clk);
        req <= 1'b1;
        instr <= ins;
        foreach (op[i]) op[i] <= {$urandom, $urandom};
        mulExc <= 5'($urandom);
        addExc <= 5'($urandom);
        denormSource <= 1'($urandom);
        incomplete_fp_operation <= inc;
        got = 0;
        for (int n = 0; n < 4 && !got; n++) begin
            @(posedge core_clk);
            req <= 1'b0;
            #1;
            got = done === 1'b1;
        end
        chk("done", !ign, got);
        if (ign || !got) return;
        chk("illegalTrap", ill, illegalTrap);
        chk("fpu_off_trap", !ill && !fpEn, fpu_off_trap);
        if (ill || !fpEn) return;
        chk("src1Basic", rn(e1, f1), src1Basic);
        chk("src2Basic", rn(e2, f2), src2Basic);
        chk("addendBasic", rn(sm ? {1'b0, e3[1:0]} : e3, f3), addendBasic);
        chk("destBasic", rn(sm ? {1'b0, ed[1:0]} : ed, fd), destBasic);
        chk("simdOp", sm, simdOp);
        chk("intOp", io, intOp);
        if (sm) begin
            chk("src1Ext", e3[2] ? rn(e1, f1) : rn({~e1[2], e1[1:0]}, f1), src1Ext);
            chk("src2Ext", rn({~e2[2], e2[1:0]}, f2), src2Ext);
            chk("addendExt", rn({1'b1, e3[1:0]}, f3), addendExt);
            chk("destExt", rn({1'b1, ed[1:0]}, fd), destExt);
        end
        fb = {64'h0, op[0]} * {64'h0, op[1]} + {64'h0, op[2]};
        fe = {64'h0, op[3]} * {64'h0, op[4]} + {64'h0, op[5]};
        if (io) begin
            chk("resultBasic", v[0] ? fb[127:64] : fb[63:0], resultBasic);
            if (sm) chk("resultExt", v[0] ? fe[127:64] : fe[63:0], resultExt);
            chk("other_fp_trap", 0, other_fp_trap);
        end else begin
            chk("roundOnce", 1, roundOnce);
            chk("negProdBasic", v[1], negProdBasic);
            chk("subAddend", v[0], subAddend);
            if (sm) chk("negProdExt", v[1] ^ ed[2], negProdExt);
            chk("resultBasic", 0, resultBasic);
            chk("other_fp_trap", inc, other_fp_trap);
            if (!inc) begin
                mt = |(mulExc & tem & FMD_MUL_TRAP_MASK) || (denormSource && ns);
                at = |(addExc & tem);
                chk("ieee_fp_trap", mt || at, ieee_fp_trap);
                chk("skipAdd", mt, skipAdd);
                if (mt) cexc = mulExc;
                else if (at) cexc = addExc & tem;
                else begin
                    cexc = mulExc | addExc;
                    aexc |= cexc;
                end
            end
        end
        if (!io) begin
            rd(FMD_ADDR_OPTION, q);
            chk("option", {sm, v[1] ^ (sm & ed[2]), mt && !inc}, q[2:0]);
        end
        rd(FMD_ADDR_STATUS, q);
        if (inc) chk("ftt", FMD_FTT_INCOMPLETE, q[16:14]);
        else chk("status", {aexc, cexc}, q[9:0]);
    endtask : issue_check

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, clkEnable, regWrite, regRead, req, denormSource} = '0;
        {regAddr, regWrData, instr, mulExc, addExc, tem, cexc, aexc, ns} = '0;
        {incomplete_fp_operation, miscompares, checks_done, cyc} = '0;
        foreach (op[i]) op[i] = '0;
        fpEn = 1'b1;
        void'($urandom(32'h6c0a387f));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        clkEnable <= 1'b1;
        rd(FMD_ADDR_CONFIG, d);
        chk("config", 32'h200, d);
        rd(FMD_ADDR_STATUS, d);
        chk("status", 0, d);
        wr(4'hc, 32'hffffffff);
        rd(4'hc, d);
        chk("unmapped", 0, d);
        @(posedge core_clk);
        clkEnable <= 1'b0;
        rd(FMD_ADDR_CONFIG, d);
        chk("frozen", 0, d);
        @(posedge core_clk);
        clkEnable <= 1'b1;
        // Random fused and integer forms under several trap enable settings.
        for (int b = 0; b < 8; b++) begin
            tem = 5'($urandom);
            ns = 1'($urandom);
            wr(FMD_ADDR_CONFIG, {22'h0, 1'b1, ns, 3'h0, tem});
            repeat (25) begin
                int k;
                k = $urandom % 3;
                r = {$urandom, $urandom};
                if (k == 2) issue_check({1'b0, 1'($urandom), 2'b00, r[32:0]}, 1'b0);
                else issue_check({2'($urandom), 2'(k + 1), r[32:0]}, 1'b0);
            end
        end
        issue_check({2'b10, 2'b00, r[32:0]}, 1'b0);
        issue_check({2'b11, 2'b11, r[32:0]}, 1'b0);
        fpEn = 1'b0;
        wr(FMD_ADDR_CONFIG, 32'h0);
        issue_check({2'b01, 2'b11, r[32:0]}, 1'b0);
        issue_check({2'b00, 2'b00, r[32:0]}, 1'b0);
        fpEn = 1'b1;
        wr(FMD_ADDR_CONFIG, 32'h200);
        issue_check({2'b00, 2'b10, r[32:0]}, 1'b1);
        wrap_up();
    end
endmodule : tb
